// ===== qdp_decoder.sv
`timescale 1ns/1ps
`include "qdp_defs.svh"

module qdp_decoder #(
    parameter int unsigned PULSE_CYC = `QDP_PULSE_CYC
) (
    // Clocking
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic clkEn,
    // Encoder phases
    input  wire logic encoderPhaseA,
    input  wire logic encoderPhaseB,
    // Pulse outputs: a counts up, b counts down
    output logic      pulseOutA,
    output logic      pulseOutB
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    qdp_pkg::qdp_phase_t rawPhase;
    qdp_pkg::qdp_phase_t cleanPhase;

    assign rawPhase.phaseA = encoderPhaseA;
    assign rawPhase.phaseB = encoderPhaseB;

    qdp_sync u_sync (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .rawPhase   (rawPhase),
        .cleanPhase (cleanPhase)
    );

    // ----------------------------------------------------------------
    // Direction decode
    // ----------------------------------------------------------------
    // Forward means phase A leads phase B. After a single-phase change
    // the new A differs from the old B exactly when the motion is up.
    function automatic qdp_pkg::qdp_dir_t stepDir(
        input qdp_pkg::qdp_phase_t prev,
        input qdp_pkg::qdp_phase_t cur
    );
        logic chgA;
        logic chgB;
        chgA = prev.phaseA ^ cur.phaseA;
        chgB = prev.phaseB ^ cur.phaseB;
        if (chgA == chgB) begin
            // No change, or both at once: the order is lost.
            stepDir = qdp_pkg::QDP_DIR_NONE;
        end else if (cur.phaseA ^ prev.phaseB) begin
            stepDir = qdp_pkg::QDP_DIR_UP;
        end else begin
            stepDir = qdp_pkg::QDP_DIR_DOWN;
        end
    endfunction : stepDir

    qdp_pkg::qdp_phase_t prev_q, prev_d;
    qdp_pkg::qdp_dir_t   dir;

    always_comb begin
        prev_d = cleanPhase;
        dir    = stepDir(prev_q, cleanPhase);
    end

    // ----------------------------------------------------------------
    // Pulse generation
    // ----------------------------------------------------------------
    // The pulse is far shorter than the edge spacing, so a pulse always
    // ends before the next step. A step that still lands inside a pulse
    // (encoder too fast) restarts the width on the new direction rather
    // than being dropped.
    qdp_pkg::qdp_state_t      state_q, state_d;
    logic [`QDP_CNT_W-1:0]    cnt_q, cnt_d;
    logic                     outA_q, outA_d;
    logic                     outB_q, outB_d;

    localparam logic [`QDP_CNT_W-1:0] PulseLast =
        `QDP_CNT_W'(PULSE_CYC - 1);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (dir == qdp_pkg::QDP_DIR_UP) begin
            state_d = qdp_pkg::QDP_PULSE_UP;
            cnt_d   = '0;
        end else if (dir == qdp_pkg::QDP_DIR_DOWN) begin
            state_d = qdp_pkg::QDP_PULSE_DN;
            cnt_d   = '0;
        end else begin
            case (state_q)
                qdp_pkg::QDP_IDLE: begin
                    cnt_d = '0;
                end
                qdp_pkg::QDP_PULSE_UP, qdp_pkg::QDP_PULSE_DN: begin
                    if (cnt_q == PulseLast) begin
                        state_d = qdp_pkg::QDP_IDLE;
                        cnt_d   = '0;
                    end else begin
                        cnt_d = cnt_q + `QDP_CNT_W'(1);
                    end
                end
                default: begin
                    state_d = qdp_pkg::QDP_IDLE;
                    cnt_d   = '0;
                end
            endcase
        end
        outA_d = (state_d == qdp_pkg::QDP_PULSE_UP);
        outB_d = (state_d == qdp_pkg::QDP_PULSE_DN);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prev_q  <= `QDP_SYNC_RST;
            state_q <= qdp_pkg::QDP_IDLE;
            cnt_q   <= '0;
            outA_q  <= 1'b0;
            outB_q  <= 1'b0;
        end else if (clkEn) begin
            prev_q  <= prev_d;
            state_q <= state_d;
            cnt_q   <= cnt_d;
            outA_q  <= outA_d;
            outB_q  <= outB_d;
        end
    end

    assign pulseOutA = outA_q;
    assign pulseOutB = outB_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Helper: cycles the current pulse has stood high.
    logic [`QDP_CNT_W-1:0] hiCnt_q, hiCnt_d;
    always_comb begin
        hiCnt_d = (outA_q | outB_q) ? hiCnt_q + `QDP_CNT_W'(1) : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hiCnt_q <= '0;
        end else if (clkEn) begin
            hiCnt_q <= hiCnt_d;
        end
    end

    sequence s_upStep;
        clkEn && dir == qdp_pkg::QDP_DIR_UP;
    endsequence

    sequence s_dnStep;
        clkEn && dir == qdp_pkg::QDP_DIR_DOWN;
    endsequence

    property p_upPulse;
        @(posedge clk_sys) disable iff (!rst_b)
        s_upStep |=> pulseOutA && !pulseOutB;
    endproperty
    a_upPulse: assert property (p_upPulse)
        else $error("Up step did not raise the up output.");

    property p_dnPulse;
        @(posedge clk_sys) disable iff (!rst_b)
        s_dnStep |=> pulseOutB && !pulseOutA;
    endproperty
    a_dnPulse: assert property (p_dnPulse)
        else $error("Down step did not raise the down output.");

    property p_exclusive;
        @(posedge clk_sys) disable iff (!rst_b)
        !(pulseOutA && pulseOutB);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("Both pulse outputs high together.");

    property p_width;
        @(posedge clk_sys) disable iff (!rst_b)
        (pulseOutA || pulseOutB) |-> hiCnt_q < `QDP_CNT_W'(PULSE_CYC);
    endproperty
    a_width: assert property (p_width)
        else $error("Output pulse wider than its set width.");

    property p_fullWidth;
        @(posedge clk_sys) disable iff (!rst_b)
        // A reset that cuts a running pulse is not an early end.
        ($fell(pulseOutA) || $fell(pulseOutB)) &&
        $past(clkEn) && $past(rst_b)
            |-> $past(hiCnt_q) == `QDP_CNT_W'(PULSE_CYC - 1);
    endproperty
    a_fullWidth: assert property (p_fullWidth)
        else $error("Output pulse ended early.");

    property p_noBoth;
        @(posedge clk_sys) disable iff (!rst_b)
        (prev_q.phaseA != cleanPhase.phaseA) &&
        (prev_q.phaseB != cleanPhase.phaseB) |-> dir == qdp_pkg::QDP_DIR_NONE;
    endproperty
    a_noBoth: assert property (p_noBoth)
        else $error("Simultaneous change produced a step.");

    property p_edgeStep;
        @(posedge clk_sys) disable iff (!rst_b)
        ((prev_q.phaseA != cleanPhase.phaseA) !=
         (prev_q.phaseB != cleanPhase.phaseB)) |->
            dir != qdp_pkg::QDP_DIR_NONE;
    endproperty
    a_edgeStep: assert property (p_edgeStep)
        else $error("Single-phase edge produced no step.");

    property p_order;
        @(posedge clk_sys) disable iff (!rst_b)
        (prev_q == 2'h0 && cleanPhase == 2'h1) |->
            dir == qdp_pkg::QDP_DIR_UP;
    endproperty
    a_order: assert property (p_order)
        else $error("A leading B not decoded as up.");

    property p_quiet;
        @(posedge clk_sys) disable iff (!rst_b)
        (pulseOutA && clkEn && dir == qdp_pkg::QDP_DIR_NONE &&
         hiCnt_q == `QDP_CNT_W'(PULSE_CYC - 1)) |=> !pulseOutA;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Pulse did not end at its width.");

endmodule : qdp_decoder

// ===== qdp_defs.svh
`ifndef QDP_DEFS_SVH
`define QDP_DEFS_SVH

// Clock rate and documented timing figures.
`define QDP_CLK_HZ          50000000
`define QDP_PULSE_US        250
`define QDP_MIN_SPACING_US  750
// Cycles per output pulse; a longest time rounds down.
`define QDP_PULSE_CYC       ((`QDP_CLK_HZ / 1000000) * `QDP_PULSE_US)
// Cycles of the tightest input edge spacing.
`define QDP_SPACING_CYC     ((`QDP_CLK_HZ / 1000000) * `QDP_MIN_SPACING_US)
// Width of the pulse-width counter.
`define QDP_CNT_W           16
// Position of each phase in the packed pair.
`define QDP_PH_A_BIT        0
`define QDP_PH_B_BIT        1
// Reset value of the synchroniser stages.
`define QDP_SYNC_RST        2'h0

`endif

// ===== qdp_pkg.sv
package qdp_pkg;

    // Both encoder phases sampled together.
    typedef struct packed {
        logic phaseB;
        logic phaseA;
    } qdp_phase_t;

    // Direction of a decoded step.
    typedef enum logic [2:0] {
        QDP_DIR_NONE = 3'h1,
        QDP_DIR_UP   = 3'h2,
        QDP_DIR_DOWN = 3'h4
    } qdp_dir_t;

    // Output pulser states.
    typedef enum logic [2:0] {
        QDP_IDLE     = 3'h1,
        QDP_PULSE_UP = 3'h2,
        QDP_PULSE_DN = 3'h4
    } qdp_state_t;

endpackage : qdp_pkg

// ===== qdp_sync.sv
`timescale 1ns/1ps
`include "qdp_defs.svh"

// Three-stage synchroniser for both phases; a change is accepted once
// the second and third stages agree.
module qdp_sync (
    // Clocking
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               clkEn,
    // Raw and filtered phases
    input  wire qdp_pkg::qdp_phase_t rawPhase,
    output qdp_pkg::qdp_phase_t      cleanPhase
);

    qdp_pkg::qdp_phase_t s1_q, s2_q, s3_q, clean_q;
    qdp_pkg::qdp_phase_t s1_d, s2_d, s3_d, clean_d;

    always_comb begin
        s1_d    = rawPhase;
        s2_d    = s1_q;
        s3_d    = s2_q;
        clean_d = clean_q;
        if (s2_q[`QDP_PH_A_BIT] == s3_q[`QDP_PH_A_BIT]) begin
            clean_d[`QDP_PH_A_BIT] = s3_q[`QDP_PH_A_BIT];
        end
        if (s2_q[`QDP_PH_B_BIT] == s3_q[`QDP_PH_B_BIT]) begin
            clean_d[`QDP_PH_B_BIT] = s3_q[`QDP_PH_B_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1_q    <= `QDP_SYNC_RST;
            s2_q    <= `QDP_SYNC_RST;
            s3_q    <= `QDP_SYNC_RST;
            clean_q <= `QDP_SYNC_RST;
        end else if (clkEn) begin
            s1_q    <= s1_d;
            s2_q    <= s2_d;
            s3_q    <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign cleanPhase = clean_q;

endmodule : qdp_sync

// ===== qdp_count_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Up and down pulse counting channels
// ----------------------------------------------------------------------
module qdp_count_model #(
    parameter int MULT = 1
) (
    // Clocking
    input wire logic clk_sys,
    // Pulse channels
    input wire logic pulseOutA,
    input wire logic pulseOutB
);
    int   upCount   = 0;
    int   downCount = 0;
    int   stage     = 0;
    logic prevA     = 1'b0;
    logic prevB     = 1'b0;

    // Each channel counts rising edges on its own.
    always @(posedge clk_sys) begin
        if (pulseOutA === 1'b1 && prevA !== 1'b1) upCount++;
        if (pulseOutB === 1'b1 && prevB !== 1'b1) downCount++;
        prevA = pulseOutA;
        prevB = pulseOutB;
    end

    // Counts are scaled with zero offset; up is added before down is
    // taken off, both written back to the same stage.
    task automatic take(output int up, output int dn);
        up = upCount;
        dn = downCount;
        stage = stage + up * MULT;
        stage = stage - dn * MULT;
        upCount = 0;
        downCount = 0;
    endtask : take
endmodule : qdp_count_model

// ===== quadrature_direction_pulser_test.sv
`timescale 1ns/1ps

module quadrature_direction_pulser_test;
    localparam int PW  = 8;
    localparam int GAP = 20;

    logic clk_sys = 1'b0;
    logic rst_b   = 1'b0;
    logic clkEn   = 1'b1;
    logic phA     = 1'b0;
    logic phB     = 1'b0;
    wire  pulseOutA;
    wire  pulseOutB;
    int   num_errors = 0;
    int   n_checks   = 0;
    int   expStage   = 0;

    always #10 clk_sys = ~clk_sys;

    qdp_decoder #(.PULSE_CYC(PW)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
        .encoderPhaseA(phA), .encoderPhaseB(phB),
        .pulseOutA(pulseOutA), .pulseOutB(pulseOutB));

    qdp_count_model model (
        .clk_sys(clk_sys), .pulseOutA(pulseOutA), .pulseOutB(pulseOutB));

    // ------------------------------------------------------------------
    // Compare and drive helpers
    // ------------------------------------------------------------------
    task automatic checkInt(string what, int exp, int got);
        n_checks++;
        if (exp != got) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : checkInt

    task automatic checkBit(string what, logic exp, logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit

    task automatic step(logic a, logic b);
        @(posedge clk_sys);
        #1;
        phA = a;
        phB = b;
        repeat (GAP) @(posedge clk_sys);
    endtask : step

    // Pulls both channel counts and checks them and the running stage.
    task automatic counts(string what, int expUp, int expDn);
        int up;
        int dn;
        model.take(up, dn);
        expStage = expStage + expUp - expDn;
        checkInt({what, " up"}, expUp, up);
        checkInt({what, " down"}, expDn, dn);
        checkInt({what, " stage"}, expStage, model.stage);
    endtask : counts

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic scenUp();
        step(1, 0); step(1, 1); step(0, 1); step(0, 0);
        counts("up cycle", 4, 0);
    endtask : scenUp

    task automatic scenDown();
        step(0, 1); step(1, 1); step(1, 0); step(0, 0);
        counts("down cycle", 0, 4);
    endtask : scenDown

    task automatic scenWidth();
        int lat;
        int w;
        lat = 0;
        w = 0;
        @(posedge clk_sys);
        #1;
        phA = 1'b1;
        while (pulseOutA !== 1'b1 && lat < 10) begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
        checkInt("latency", 5, lat);
        checkBit("down idle", 1'b0, pulseOutB);
        while (pulseOutA === 1'b1 && w < 3 * PW) begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        checkInt("pulse width", PW, w);
        repeat (GAP) @(posedge clk_sys);
        step(0, 0);
        counts("swing", 1, 1);
    endtask : scenWidth

    task automatic scenBoth();
        step(1, 1); step(0, 0);
        counts("both change", 0, 0);
    endtask : scenBoth

    // A held enable must not lose the step, only delay it.
    task automatic scenFreeze();
        @(posedge clk_sys);
        #1;
        clkEn = 1'b0;
        step(1, 0);
        counts("frozen", 0, 0);
        #1;
        clkEn = 1'b1;
        repeat (GAP) @(posedge clk_sys);
        counts("thawed", 1, 0);
        step(0, 0);
        counts("back", 0, 1);
    endtask : scenFreeze

    // A reset in mid-pulse must clear the output at once.
    task automatic scenReset();
        @(posedge clk_sys);
        #1;
        phA = 1'b1;
        repeat (7) @(posedge clk_sys);
        #1;
        checkBit("pulse before reset", 1'b1, pulseOutA);
        rst_b = 1'b0;
        phA = 1'b0;
        @(posedge clk_sys);
        #1;
        checkBit("reset clears", 1'b0, pulseOutA);
        @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        repeat (GAP) @(posedge clk_sys);
        counts("reset", 1, 0);
    endtask : scenReset

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // The run needs a few hundred cycles; this bound is far beyond it.
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        repeat (GAP) @(posedge clk_sys);
        counts("after reset", 0, 0);
        scenUp();
        scenDown();
        scenWidth();
        scenBoth();
        scenFreeze();
        scenReset();
        summarize();
    end
endmodule : quadrature_direction_pulser_test
